// ### logic/ramp_defines.svh
// Offsets, field positions, reset values and timing counts of the ramp block.
`ifndef RAMP_DEFINES_SVH
`define RAMP_DEFINES_SVH

// ==========================================================================
// Memory sizes and address map
// ==========================================================================
`define COEF_W 28
`define TGT_W 34
`define PRAM_WORDS 1024
`define RAMP_LOCS 64
`define SAFE_SLOTS 5
`define SLOT_ADDR_W 12
`define PRAM_LAST 12'h03FF
`define RAMP_FIRST 12'h0A00
`define RAMP_LAST 12'h0A3F

// ==========================================================================
// Target word fields
// ==========================================================================
`define CURVE_MSB 33
`define CURVE_LSB 32
`define RATE_MSB 31
`define RATE_LSB 28
`define RECALC_BIT 31
`define CT_CODE_MSB 30
`define CT_CODE_LSB 28
`define CT_DATA_MSB 27
`define CT_DATA_LSB 12
`define CT_COUNT_MSB 11
`define CT_COUNT_MAX 12'hFFF

// ==========================================================================
// Reset values and step constants
// ==========================================================================
`define TGT_RESET 34'h0_5080_0000
`define SLEW_RESET 28'h080_0000
`define LIN_STEP_BASE 29'h004_0000
`define EXP_SHIFT_BASE 5'h03
`define CT_SHIFT_BASE 4'h6
`define STEP_MIN 29'h0000_0001

// ==========================================================================
// Timing
// ==========================================================================
`define SYS_CLK_MHZ 20
`define DMEM_CLR_US 100
`define DMEM_CLR_CYCLES (`DMEM_CLR_US * `SYS_CLK_MHZ)

`endif

// ### logic/ramp_pkg.sv
// Types shared by the ramp control block and its step unit.
`include "ramp_defines.svh"
package ramp_pkg;

  // Curve selector codes of a target word.
  typedef enum logic [1:0] {
    CURVE_LINEAR = 2'h0,
    CURVE_CONST_DB = 2'h1,
    CURVE_RC = 2'h2,
    CURVE_CONST_TIME = 2'h3
  } curve_t;

  // Sequencer states.
  typedef enum logic [1:0] {ST_INIT, ST_IDLE, ST_SWEEP, ST_SAFE} ctl_state_t;

  // One holding slot: written flag, control-port address and data.
  typedef struct packed {
    logic used;
    logic [`SLOT_ADDR_W-1:0] addr;
    logic [`TGT_W-1:0] data;
  } slot_t;

  // Whole state of the control module.
  typedef struct packed {
    ctl_state_t st;
    logic [9:0] idx;
    logic [2:0] slot_ptr;
    logic [2:0] lr_sync;
    logic param_go;
    logic ramp_go;
    logic frame_pend;
    slot_t [`SAFE_SLOTS-1:0] slots;
    logic [11:0] clr_cnt;
    logic clr_busy;
    logic zero_hold;
    logic stall;
    logic allzero;
    logic ramp_done;
    logic ready;
  } ctl_reg_t;

endpackage

// ### logic/step_if.sv
// Signals between the ramp sequencer and the per-frame step unit.
`timescale 1ns/1ps
`default_nettype none
`include "ramp_defines.svh"
interface step_if;
  import ramp_pkg::*;
  logic [`COEF_W-1:0] cur; // Present slew value.
  logic [`COEF_W-1:0] tgt; // Effective target.
  logic [`COEF_W-1:0] ct_step; // Stored constant-time step.
  curve_t curve; // Curve selector.
  logic [3:0] rate; // Rate code.
  logic [`COEF_W-1:0] nxt; // Value after one step.
  modport eng (output cur, tgt, ct_step, curve, rate, input nxt);
  modport unit (input cur, tgt, ct_step, curve, rate, output nxt);
endinterface
`default_nettype wire

// ### logic/slew_step_unit.sv
// Computes one frame step of a slew value toward its target.
`timescale 1ns/1ps
`default_nettype none
`include "ramp_defines.svh"
module slew_step_unit (
  // Step request and result.
  step_if.unit s
);
  import ramp_pkg::*;

  // Magnitude of a signed 29-bit value.
  function automatic logic [28:0] abs29(input logic [28:0] v);
    abs29 = v[28] ? (~v + `STEP_MIN) : v;
  endfunction

  logic [28:0] cur_x; // Sign-extended current value.
  logic [28:0] tgt_x; // Sign-extended target.
  logic [28:0] diff; // Target minus current.
  logic [28:0] step; // Step magnitude.
  logic [28:0] sum; // Candidate next value.

  // ==========================================================================
  // Step size and clamp
  // ==========================================================================
  // Picks the step by curve, moves toward the target and stops on it.
  always_comb
  begin
    cur_x = {s.cur[27], s.cur};
    tgt_x = {s.tgt[27], s.tgt};
    diff = tgt_x - cur_x;
    case (s.curve)
      // Fixed step, halved for each slower rate code.
      CURVE_LINEAR: step = `LIN_STEP_BASE >> s.rate; // RULE22 RULE23
      // Step follows the present value.
      CURVE_CONST_DB: step = abs29(cur_x) >> ({1'b0, s.rate} + `EXP_SHIFT_BASE); // RULE22
      // Step follows the remaining distance.
      CURVE_RC: step = abs29(diff) >> ({1'b0, s.rate} + `EXP_SHIFT_BASE); // RULE22
      // Step precomputed by the sweep that saw the recalc flag.
      default: step = abs29({s.ct_step[27], s.ct_step}); // RULE22
    endcase
    // A zero step would stall the ramp forever.
    if (step == 29'h0000_0000)
      step = `STEP_MIN;
    sum = diff[28] ? (cur_x - step) : (cur_x + step);
    if (diff == 29'h0000_0000)
      s.nxt = s.cur;
    else if (!diff[28] && ($signed(sum) >= $signed(tgt_x)))
      s.nxt = s.tgt; // RULE27
    else if (diff[28] && ($signed(sum) <= $signed(tgt_x)))
      s.nxt = s.tgt; // RULE27
    else
      s.nxt = sum[27:0];
  end

endmodule
`default_nettype wire

// ### logic/param_ram_slew_ramp_ctrl.sv
// Coefficient memory, holding slots, core control bits and slew ramping.
// Function
// [RULE1] 1024 coefficient words of 28 bits
// [RULE2] Coefficient memory cleared to zero after reset
// [RULE3] Coefficients are two's complement 5.23
// [RULE4] Direct write steals memory from core, no handshake
// [RULE5] Five slots commit only while core is idle; ramp-memory slots here commit even while core is busy
// [RULE6] Slots never reach program memory or registers
// [RULE7] Hold and zero bits zero core registers
// [RULE8] Data clear self-clears after fixed 100 us
// [RULE9] Host silences core before bulk loading
// [RULE10] Ramp-down bit ramps volume down, release ramps up
// [RULE11] Ramp-down completion reported on status bit
// [RULE12] 64 targets, each drives its paired slew
// [RULE13] One step per frame-clock period
// [RULE14] 34-bit target: selector, rate, 5.23 data
// [RULE15] Constant time: 2.14 data plus step count
// [RULE16] Five-byte linear/dB/RC target write layout
// [RULE17] Five-byte constant-time target write layout
// [RULE18] Ramp memory written only through slots
// [RULE19] Mute forces targets to zero, release restores
// [RULE20] Constant-time locations ignore mute
// [RULE21] Selector: linear, dB, RC, constant time
// [RULE22] Step size depends on curve type
// [RULE23] Rate code zero fastest, fifteen slowest
// [RULE24] Constant time takes two to code-plus-six steps
// [RULE25] Recalc flag recomputes step then self-clears
// [RULE26] Reset targets linear rate 5 unity, slews unity
// [RULE27] Slew stops exactly at target, no overshoot
`timescale 1ns/1ps
`default_nettype none
`include "ramp_defines.svh"
module param_ram_slew_ramp_ctrl (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // Frame clock pin.
  input wire logic lrclk_i,
  // Direct coefficient port.
  input wire logic host_wr_i,
  input wire logic [9:0] host_addr_i,
  input wire logic [`COEF_W-1:0] host_wr_data_i,
  input wire logic [9:0] host_rd_addr_i,
  output logic [`COEF_W-1:0] host_rd_data_o,
  // Holding slots.
  input wire logic slot_wr_i,
  input wire logic [2:0] slot_idx_i,
  input wire logic [`SLOT_ADDR_W-1:0] slot_addr_i,
  input wire logic [`TGT_W-1:0] slot_data_i,
  input wire logic param_commit_i,
  input wire logic ramp_commit_i,
  // Core control bits.
  input wire logic core_hold_n_i,
  input wire logic core_zero_i,
  input wire logic dmem_clear_i,
  output logic dmem_clear_busy_o,
  input wire logic ramp_down_i,
  output logic ramp_done_o,
  input wire logic mute_i,
  output logic zero_hold_o,
  // Processing core side.
  input wire logic core_busy_i,
  input wire logic [9:0] core_rd_addr_i,
  output logic [`COEF_W-1:0] core_rd_data_o,
  output logic core_stall_o,
  input wire logic [5:0] slew_rd_addr_i,
  output logic [`COEF_W-1:0] slew_rd_data_o,
  // Status.
  output logic ready_o,
  output ramp_pkg::ctl_state_t ctl_state_o
);
  import ramp_pkg::*;

  localparam int DmemCycles = `DMEM_CLR_CYCLES;

  ctl_reg_t r_reg; // Registered state.
  ctl_reg_t r_next; // Next state.

  logic [`COEF_W-1:0] pram [0:`PRAM_WORDS-1]; // Coefficient memory.
  logic [`TGT_W-1:0] tram [0:`RAMP_LOCS-1]; // Target memory.
  logic [`COEF_W-1:0] sram [0:`RAMP_LOCS-1]; // Slew memory.
  logic [`COEF_W-1:0] cstep [0:`RAMP_LOCS-1]; // Constant-time steps.

  logic pram_we; // Coefficient write strobe.
  logic [9:0] pram_wa; // Coefficient write address.
  logic [`COEF_W-1:0] pram_wd; // Coefficient write data.
  logic tram_we; // Target write strobe.
  logic [5:0] tram_wa; // Target write address.
  logic [`TGT_W-1:0] tram_wd; // Target write data.
  logic sram_we; // Slew write strobe.
  logic [`COEF_W-1:0] sram_wd; // Slew write data.
  logic cstep_we; // Step write strobe.
  logic [`COEF_W-1:0] cstep_wd; // Step write data.
  logic safe_we; // Slot commit into coefficient memory.
  logic frame_tick; // Rising edge of the frame clock.
  slot_t sl; // Slot under the pointer.

  // Sweep view of the location under the index.
  logic [5:0] ra;
  logic [`TGT_W-1:0] tw;
  logic [`COEF_W-1:0] cur;
  logic is_ct;
  logic muted;
  logic [`COEF_W-1:0] raw_tgt;
  logic [`COEF_W-1:0] eff_tgt;
  logic [`COEF_W-1:0] nxt;
  logic az;

  step_if st_if ();

  // Constant-time step: distance shifted by code plus six.
  function automatic logic [`COEF_W-1:0] ct_div(
    input logic [`COEF_W-1:0] d,
    input logic [2:0] code
  );
    ct_div = $signed(d) >>> ({1'b0, code} + `CT_SHIFT_BASE); // RULE24
  endfunction

  // ==========================================================================
  // Sweep decode
  // ==========================================================================
  // The frame clock is a pin, so its edge is taken after two flops.
  assign frame_tick = r_reg.lr_sync[1] & ~r_reg.lr_sync[2]; // RULE13
  assign ra = r_reg.idx[5:0];
  assign tw = tram[ra];
  assign cur = sram[ra];
  assign is_ct = (tw[`CURVE_MSB:`CURVE_LSB] == CURVE_CONST_TIME); // RULE21
  // A constant-time 2.14 target is widened to 5.23.
  assign raw_tgt = is_ct ?
    {{3{tw[`CT_DATA_MSB]}}, tw[`CT_DATA_MSB:`CT_DATA_LSB], 9'h000} // RULE15
    : tw[`COEF_W-1:0]; // RULE14
  // Mute and ramp-down force zero except for constant time.
  assign muted = (mute_i | ramp_down_i) & ~is_ct; // RULE19 RULE20 RULE10
  assign eff_tgt = muted ? 28'h000_0000 : raw_tgt;
  assign az = r_reg.allzero & ~(muted & (nxt != 28'h000_0000));
  assign sl = r_reg.slots[r_reg.slot_ptr];

  assign st_if.cur = cur;
  assign st_if.tgt = eff_tgt;
  assign st_if.ct_step = cstep[ra];
  assign st_if.curve = curve_t'(tw[`CURVE_MSB:`CURVE_LSB]);
  assign st_if.rate = tw[`RATE_MSB:`RATE_LSB];
  assign nxt = st_if.nxt;

  slew_step_unit u_step (
    .s (st_if)
  );

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  // Sequences init, frame sweeps and slot commits, and the control bits.
  always_comb
  begin
    r_next = r_reg;
    pram_we = 1'b0;
    pram_wa = r_reg.idx;
    pram_wd = 28'h000_0000;
    tram_we = 1'b0;
    tram_wa = ra;
    tram_wd = tw;
    sram_we = 1'b0;
    sram_wd = nxt;
    cstep_we = 1'b0;
    cstep_wd = 28'h000_0000;
    safe_we = 1'b0;
    r_next.lr_sync = {r_reg.lr_sync[1:0], lrclk_i};
    if (frame_tick)
      r_next.frame_pend = 1'b1;
    // Hold low plus zero high silences the core registers.
    r_next.zero_hold = ~core_hold_n_i & core_zero_i; // RULE7
    // A direct write takes the memory from the core this cycle.
    r_next.stall = host_wr_i & r_reg.ready; // RULE4
    // Data-memory clear runs a fixed time and then drops its bit.
    if (r_reg.clr_busy)
    begin
      if (r_reg.clr_cnt == 12'(DmemCycles - 1))
        r_next.clr_busy = 1'b0; // RULE8
      else
        r_next.clr_cnt = r_reg.clr_cnt + 12'h001;
    end
    else if (dmem_clear_i)
    begin
      r_next.clr_busy = 1'b1; // RULE8
      r_next.clr_cnt = 12'h000;
    end
    if (!ramp_down_i)
      r_next.ramp_done = 1'b0;
    case (r_reg.st)
      // Clear coefficients and load ramp defaults.
      ST_INIT:
      begin
        pram_we = 1'b1; // RULE2
        if (r_reg.idx < 10'(`RAMP_LOCS))
        begin
          tram_we = 1'b1;
          tram_wd = `TGT_RESET; // RULE26
          sram_we = 1'b1;
          sram_wd = `SLEW_RESET; // RULE26
          cstep_we = 1'b1;
        end
        r_next.idx = r_reg.idx + 10'h001;
        if (r_reg.idx == 10'h3FF)
        begin
          r_next.st = ST_IDLE;
          r_next.ready = 1'b1;
        end
      end
      // A pending frame is served first, then any commit.
      ST_IDLE:
      begin
        if (r_reg.frame_pend)
        begin
          r_next.st = ST_SWEEP; // RULE13
          r_next.idx = 10'h000;
          // A tick landing in this cycle starts the next frame, not lost.
          r_next.frame_pend = frame_tick;
          r_next.allzero = 1'b1;
        end
        else if (r_reg.param_go || r_reg.ramp_go)
        begin
          r_next.st = ST_SAFE;
          r_next.slot_ptr = 3'h0;
        end
      end
      // One location per cycle, all 64 in each frame.
      ST_SWEEP:
      begin
        if (is_ct && tw[`RECALC_BIT])
        begin
          cstep_we = 1'b1; // RULE25
          cstep_wd = ct_div(eff_tgt - cur, tw[`CT_CODE_MSB:`CT_CODE_LSB]);
          tram_we = 1'b1;
          tram_wd = {tw[`TGT_W-1:32], 1'b0, tw[30:12], 12'h000}; // RULE25
        end
        else
        begin
          sram_we = 1'b1; // RULE12 RULE13
          // The low field counts steps taken toward a constant-time target.
          if (is_ct && (nxt != cur) && (tw[11:0] != `CT_COUNT_MAX))
          begin
            tram_we = 1'b1;
            tram_wd = {tw[`TGT_W-1:12], tw[`CT_COUNT_MSB:0] + 12'h001};
          end
        end
        r_next.allzero = az;
        r_next.idx = r_reg.idx + 10'h001;
        if (ra == 6'h3F)
        begin
          r_next.st = ST_IDLE;
          r_next.ramp_done = ramp_down_i & az; // RULE11
        end
      end
      // Walk the slots and commit the written ones whose kind has a pending commit.
      default:
      begin
        if (!sl.used)
          r_next.slot_ptr = r_reg.slot_ptr + 3'h1;
        else if ((sl.addr <= `PRAM_LAST) && r_reg.param_go)
        begin
          // Wait while the core or a direct write owns the memory.
          if (!core_busy_i && !host_wr_i)
          begin
            safe_we = 1'b1; // RULE5
            pram_we = 1'b1;
            pram_wa = sl.addr[9:0];
            pram_wd = sl.data[`COEF_W-1:0];
            r_next.slots[r_reg.slot_ptr].used = 1'b0;
            r_next.slot_ptr = r_reg.slot_ptr + 3'h1;
          end
        end
        else if ((sl.addr >= `RAMP_FIRST) && (sl.addr <= `RAMP_LAST) &&
                 r_reg.ramp_go)
        begin
          // Slot data reaches ramp memory only from here; init and sweep also write it.
          tram_we = 1'b1; // RULE18 RULE12 RULE16 RULE17
          tram_wa = sl.addr[5:0];
          tram_wd = sl.data;
          r_next.slots[r_reg.slot_ptr].used = 1'b0;
          r_next.slot_ptr = r_reg.slot_ptr + 3'h1;
        end
        else if ((sl.addr > `PRAM_LAST) &&
                 ((sl.addr < `RAMP_FIRST) || (sl.addr > `RAMP_LAST)))
        begin
          // Any other space is unreachable and the slot is dropped.
          r_next.slots[r_reg.slot_ptr].used = 1'b0; // RULE6
          r_next.slot_ptr = r_reg.slot_ptr + 3'h1;
        end
        else
          r_next.slot_ptr = r_reg.slot_ptr + 3'h1;
        if (r_next.slot_ptr == 3'(`SAFE_SLOTS))
        begin
          r_next.st = ST_IDLE;
          r_next.param_go = 1'b0;
          r_next.ramp_go = 1'b0;
        end
      end
    endcase
    // A direct write has priority over every other coefficient write.
    if (host_wr_i && r_reg.ready)
    begin
      pram_we = 1'b1; // RULE4
      pram_wa = host_addr_i;
      pram_wd = host_wr_data_i;
    end
    // New commits and slot writes win over the clears above.
    if (param_commit_i)
      r_next.param_go = 1'b1;
    if (ramp_commit_i)
      r_next.ramp_go = 1'b1;
    if (slot_wr_i && (slot_idx_i < 3'(`SAFE_SLOTS)))
      r_next.slots[slot_idx_i] = '{1'b1, slot_addr_i, slot_data_i}; // RULE5
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  // Registers the whole state under the asynchronous reset.
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end

  // ==========================================================================
  // Memories
  // ==========================================================================
  // Memory writes; contents are set by the init walk, not by reset.
  always_ff @(posedge sys_clk_i)
  begin
    if (pram_we)
      pram[pram_wa] <= pram_wd; // RULE1
    if (tram_we)
      tram[tram_wa] <= tram_wd;
    if (sram_we)
      sram[ra] <= sram_wd;
    if (cstep_we)
      cstep[ra] <= cstep_wd;
  end

  // Registered read ports; the core sees zero while a direct write runs.
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      host_rd_data_o <= 28'h000_0000;
      core_rd_data_o <= 28'h000_0000;
      slew_rd_data_o <= 28'h000_0000;
    end
    else
    begin
      host_rd_data_o <= pram[host_rd_addr_i]; // RULE3
      core_rd_data_o <= (host_wr_i & r_reg.ready) ?
        28'h000_0000 : pram[core_rd_addr_i]; // RULE4
      slew_rd_data_o <= sram[slew_rd_addr_i];
    end
  end

  // Status outputs straight from the state register.
  assign dmem_clear_busy_o = r_reg.clr_busy;
  assign ramp_done_o = r_reg.ramp_done;
  assign zero_hold_o = r_reg.zero_hold;
  assign core_stall_o = r_reg.stall;
  assign ready_o = r_reg.ready;
  assign ctl_state_o = r_reg.st;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  int unsigned clr_len; // Length of the current clear.
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      clr_len <= 0;
    else
      clr_len <= r_reg.clr_busy ? clr_len + 1 : 0;
  end

  sequence s_frame_start;
    r_reg.st == ST_IDLE && r_reg.frame_pend;
  endsequence
  sequence s_sweep_entry;
    r_reg.st == ST_SWEEP && r_reg.idx == 10'h000;
  endsequence

  property p_zero_hold;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (!core_hold_n_i && core_zero_i) |=> zero_hold_o;
  endproperty
  a_zero_hold: assert property (p_zero_hold) else $error("hold not applied"); // RULE7

  property p_clear_len;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    $fell(dmem_clear_busy_o) |-> clr_len == DmemCycles;
  endproperty
  a_clear_len: assert property (p_clear_len) else $error("clear length"); // RULE8

  property p_stall;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (host_wr_i && ready_o) |=> core_stall_o && core_rd_data_o == 0;
  endproperty
  a_stall: assert property (p_stall) else $error("no stall on write"); // RULE4

  property p_safe_idle;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    core_busy_i |-> !safe_we;
  endproperty
  a_safe_idle: assert property (p_safe_idle) else $error("slot commit busy"); // RULE5

  property p_sweep;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    s_frame_start |=> s_sweep_entry ##63 (r_reg.st == ST_SWEEP) ##1
      (r_reg.st == ST_IDLE);
  endproperty
  a_sweep: assert property (p_sweep) else $error("sweep length"); // RULE13

  property p_no_overshoot;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (r_reg.st == ST_SWEEP && sram_we) |->
      ($signed(cur) <= $signed(eff_tgt) ?
        ($signed(nxt) >= $signed(cur) && $signed(nxt) <= $signed(eff_tgt)) :
        ($signed(nxt) <= $signed(cur) && $signed(nxt) >= $signed(eff_tgt)));
  endproperty
  a_no_overshoot: assert property (p_no_overshoot) else $error("overshoot"); // RULE27

  property p_mute;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (r_reg.st == ST_SWEEP && mute_i) |->
      (is_ct ? eff_tgt == raw_tgt : eff_tgt == 0);
  endproperty
  a_mute: assert property (p_mute) else $error("mute target"); // RULE19

  property p_ramp_done;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    $rose(ramp_done_o) |-> $past(ramp_down_i) && $past(r_reg.st) == ST_SWEEP;
  endproperty
  a_ramp_done: assert property (p_ramp_done) else $error("done early"); // RULE11

  property p_init_zero;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (r_reg.st == ST_INIT) |-> pram_we && pram_wd == 0 && !ready_o;
  endproperty
  a_init_zero: assert property (p_init_zero) else $error("init not zero"); // RULE2

endmodule
`default_nettype wire

// ### verif/host_model.sv
// Host model driving the direct and holding-slot ports.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Clock.
  input wire logic sys_clk_i,
  // Requests toward the block.
  output logic host_wr_o,
  output logic [9:0] host_addr_o,
  output logic [27:0] host_wr_data_o,
  output logic slot_wr_o,
  output logic [2:0] slot_idx_o,
  output logic [11:0] slot_addr_o,
  output logic [33:0] slot_data_o,
  output logic param_commit_o,
  output logic ramp_commit_o
);
  // Everything idle at time zero.
  initial
  begin
    {host_wr_o, slot_wr_o, param_commit_o, ramp_commit_o} = 4'h0;
    {host_addr_o, host_wr_data_o, slot_idx_o} = '0;
    {slot_addr_o, slot_data_o} = '0;
  end
  // One direct word; the data lines show its inverse once released.
  task automatic wr(input logic [9:0] a, input logic [27:0] d);
    host_addr_o = a;
    host_wr_data_o = d;
    host_wr_o = 1'b1;
    @(posedge sys_clk_i);
    #1;
    host_wr_o = 1'b0;
    host_wr_data_o = ~d;
  endtask
  // Ramp memory is only ever reached through this slot path.
  task automatic slot(input logic [2:0] i, input logic [11:0] a,
                      input logic [33:0] d);
    {slot_idx_o, slot_addr_o, slot_data_o} = {i, a, d};
    slot_wr_o = 1'b1;
    @(posedge sys_clk_i);
    #1;
    slot_wr_o = 1'b0;
    slot_data_o = ~d;
    // Let one edge see the strobe low before the next slot write.
    @(posedge sys_clk_i);
    #1;
  endtask
  // One commit pulse, ramp slots when r is set.
  task automatic commit(input logic r);
    {ramp_commit_o, param_commit_o} = {r, ~r};
    @(posedge sys_clk_i);
    #1;
    {ramp_commit_o, param_commit_o} = 2'h0;
  endtask
endmodule
`default_nettype wire

// ### verif/param_ram_slew_ramp_ctrl_bench.sv
// Self-checking bench of the coefficient and slew ramp block.
`timescale 1ns/1ps
`default_nettype none
module param_ram_slew_ramp_ctrl_bench;
  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic lrclk_i = 1'b0;
  logic [9:0] host_rd_addr_i = '0;
  logic [5:0] slew_rd_addr_i = '0;
  logic core_hold_n_i = 1'b1;
  logic core_zero_i = 1'b0;
  logic dmem_clear_i = 1'b0;
  logic ramp_down_i = 1'b0;
  logic mute_i = 1'b0;
  logic core_busy_i = 1'b0;
  logic hw, sw, pc, rc, busy, done, zh, stall, ready;
  logic [9:0] ha;
  logic [27:0] hd, hrd, crd, srd;
  logic [2:0] si;
  logic [11:0] sa;
  logic [33:0] sd;
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;
  // Clock at 20 MHz.
  initial
  begin
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  host_model host (.sys_clk_i(sys_clk_i), .host_wr_o(hw),
    .host_addr_o(ha), .host_wr_data_o(hd), .slot_wr_o(sw),
    .slot_idx_o(si), .slot_addr_o(sa), .slot_data_o(sd),
    .param_commit_o(pc), .ramp_commit_o(rc));
  param_ram_slew_ramp_ctrl dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .lrclk_i(lrclk_i), .host_wr_i(hw), .host_addr_i(ha),
    .host_wr_data_i(hd), .host_rd_addr_i(host_rd_addr_i),
    .host_rd_data_o(hrd), .slot_wr_i(sw), .slot_idx_i(si),
    .slot_addr_i(sa), .slot_data_i(sd), .param_commit_i(pc),
    .ramp_commit_i(rc), .core_hold_n_i(core_hold_n_i),
    .core_zero_i(core_zero_i), .dmem_clear_i(dmem_clear_i),
    .dmem_clear_busy_o(busy), .ramp_down_i(ramp_down_i),
    .ramp_done_o(done), .mute_i(mute_i), .zero_hold_o(zh),
    .core_busy_i(core_busy_i), .core_rd_addr_i(10'h3FF),
    .core_rd_data_o(crd),
    .core_stall_o(stall), .slew_rd_addr_i(slew_rd_addr_i),
    .slew_rd_data_o(srd), .ready_o(ready), .ctl_state_o());
  // Step just past the rising edge so drives never race the design.
  task automatic cyc();
    @(posedge sys_clk_i);
    #1;
  endtask
  // Compares one result and counts it.
  task automatic chk(input logic [27:0] g, input logic [27:0] e);
    comparisons++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Registered reads of coefficient and slew words.
  task automatic rd(input logic [9:0] a, input logic [27:0] e);
    host_rd_addr_i = a;
    cyc();
    chk(hrd, e);
  endtask
  task automatic rds(input logic [5:0] a, input logic [27:0] e);
    slew_rd_addr_i = a;
    cyc();
    chk(srd, e);
  endtask
  // Frames of 100 cycles, long enough for a full sweep.
  task automatic frames(input int n);
    repeat (n)
    begin
      lrclk_i = 1'b1;
      repeat (50) cyc();
      lrclk_i = 1'b0;
      repeat (50) cyc();
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic results();
    $display("Counts: %0d compared, %0d failed", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Hang guard well above the expected run of about 13100 cycles.
  always @(posedge sys_clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      results();
    end
  end
  // Main sequence.
  initial
  begin
    repeat (3) cyc();
    nrst_i = 1'b1;
    for (int i = 0; i < 1100 && ready !== 1'b1; i++) cyc();
    chk({27'h0, ready}, 28'h1);
    rd(10'h3FF, 28'h0);
    rds(6'h3F, 28'h080_0000);
    $display("Test init done");
    host.wr(10'h3FF, 28'h080_0000);
    chk({stall, crd}, {1'b1, 28'h0});
    rd(10'h3FF, 28'h080_0000);
    chk({stall, crd}, {1'b0, 28'h080_0000});
    $display("Test direct done");
    host.slot(3'h0, 12'h005, 34'h0_0123_4567);
    host.slot(3'h1, 12'h400, 34'h0_0FFF_FFFF);
    host.slot(3'h2, 12'hA00, 34'h0_0000_0000);
    core_busy_i = 1'b1;
    host.commit(1'b0);
    repeat (80) cyc();
    rd(10'h005, 28'h0);
    core_busy_i = 1'b0;
    repeat (8) cyc();
    rd(10'h005, 28'h123_4567);
    rd(10'h000, 28'h0);
    rds(6'h00, 28'h080_0000);
    host.commit(1'b1);
    repeat (80) cyc();
    frames(1);
    rds(6'h00, 28'h07C_0000);
    frames(40);
    rds(6'h00, 28'h0);
    host.slot(3'h0, 12'hA02, 34'h3_8600_0000);
    host.commit(1'b1);
    repeat (8) cyc();
    frames(1);
    rds(6'h02, 28'h080_0000);
    $display("Test ramp done");
    for (int i = 0; i < 2; i++)
    begin
      {ramp_down_i, mute_i} = i ? 2'h2 : 2'h1;
      frames(1);
      rds(6'h01, 28'h07F_E000);
      {ramp_down_i, mute_i} = 2'h0;
      frames(1);
      rds(6'h01, 28'h080_0000);
    end
    rds(6'h02, 28'h084_0000);
    $display("Test mute done");
    for (int i = 0; i < 64; i++)
    begin
      host.slot(3'(i % 5), 12'hA00 + 12'(i), 34'h0_0080_0000);
      if (i % 5 == 4 || i == 63)
      begin
        host.commit(1'b1);
        repeat (8) cyc();
      end
    end
    ramp_down_i = 1'b1;
    frames(34);
    chk({27'h0, done}, 28'h1);
    ramp_down_i = 1'b0;
    cyc();
    chk({27'h0, done}, 28'h0);
    frames(16);
    rds(6'h01, 28'h040_0000);
    $display("Test ramp down done");
    {core_hold_n_i, core_zero_i} = 2'h1;
    repeat (2) cyc();
    chk({27'h0, zh}, 28'h1);
    host.wr(10'h001, 28'h000_0003);
    dmem_clear_i = 1'b1;
    cyc();
    dmem_clear_i = 1'b0;
    repeat (1999) cyc();
    chk({27'h0, busy}, 28'h1);
    cyc();
    chk({27'h0, busy}, 28'h0);
    {core_hold_n_i, core_zero_i} = 2'h2;
    repeat (2) cyc();
    chk({27'h0, zh}, 28'h0);
    rd(10'h001, 28'h000_0003);
    $display("Test core control done");
    results();
  end
endmodule
`default_nettype wire
